// ### eic_pkg.sv
// constants for the external interrupt configuration block
package eic_pkg;
    // register addresses (index on the plain register port)
    localparam logic [1:0] SENS_ADDR = 2'h0;
    localparam logic [1:0] PSEL_ADDR = 2'h1;
    localparam logic [1:0] STAT_ADDR = 2'h2;
    localparam logic [1:0] MASK_ADDR = 2'h3;
    // reset values
    localparam logic [7:0] SENS_RESET = 8'h00;
    localparam logic [7:0] PSEL_RESET = 8'h0C;
    localparam logic [3:0] MASK_RESET = 4'h0;
    // trigger codes
    localparam logic [1:0] TRIG_FALL_LOW = 2'h0;
    localparam logic [1:0] TRIG_RISE = 2'h1;
    localparam logic [1:0] TRIG_FALL = 2'h2;
    localparam logic [1:0] TRIG_BOTH = 2'h3;
    // field width and line count
    localparam int CODE_W = 2;
    localparam int LINES = 4;
    // pin choice that feeds the non-waking source on line 2
    localparam logic [1:0] LINE2_NOWAKE_CHOICE = 2'h1;
    // line 3 choice with no pin behind it
    localparam logic [1:0] LINE3_NONE_CHOICE = 2'h3;
endpackage : eic_pkg

// ### eic_line.sv
// one external line: synchroniser, trigger detect and pending latch
`timescale 1ns/1ns
module eic_line (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // source and configuration
    input wire logic pin_raw,
    input wire logic source_valid,
    input wire logic [1:0] trigger_code,
    input wire logic code_changed,
    input wire logic ack,
    // results
    output logic pending,
    output logic event_pulse
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic pend_reg;
    logic rise;
    logic fall;
    logic hit;

    // two-stage synchroniser, then one more sample for edges
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~prev_reg;
    assign fall = ~sync2_reg & prev_reg;

    // decode trigger code
    always_comb begin
        unique case (trigger_code)
            eic_pkg::TRIG_FALL_LOW: hit = ~sync2_reg;
            eic_pkg::TRIG_RISE: hit = rise;
            eic_pkg::TRIG_FALL: hit = fall;
            eic_pkg::TRIG_BOTH: hit = rise | fall;
        endcase
    end

    // pending latch: a code change discards it, service clears it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pend_reg <= 1'b0;
        end else if (code_changed) begin
            pend_reg <= 1'b0;
        end else if (source_valid && hit) begin
            pend_reg <= 1'b1;
        end else if (ack) begin
            pend_reg <= 1'b0;
        end
    end

    assign pending = pend_reg;
    assign event_pulse = source_valid & hit & ~code_changed;
endmodule : eic_line

// ### eic_top.sv
// external interrupt configuration: registers, pin routing and request lines
`timescale 1ns/1ns
module eic_top (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // port pins
    input wire logic [7:0] port_a_pins,
    input wire logic [6:0] port_b_pins,
    // core side
    input wire logic core_int_mask,
    input wire logic halt_mode,
    input wire logic [3:0] service_ack,
    output logic [3:0] int_request,
    output logic halt_wake,
    output logic irq
);
    logic [7:0] sensitivity_control_reg;
    logic [7:0] source_pin_select_reg;
    logic [3:0] status_reg;
    logic [3:0] mask_reg;
    logic [7:0] rdata_reg;
    logic [3:0] req_reg;
    logic wake_reg;
    logic irq_reg;
    logic [3:0] pending;
    logic [3:0] event_pulse;
    logic [3:0] code_changed;
    logic [3:0] src_pin;
    logic [3:0] src_valid;
    logic [3:0] wake_ok;
    logic sens_write;
    logic [1:0] line3_pin_choice;
    logic [1:0] line2_pin_choice;
    logic [1:0] line1_pin_choice;
    logic [1:0] line0_pin_choice;

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------
    assign sens_write = reg_write && reg_addr == eic_pkg::SENS_ADDR && core_int_mask;

    // sensitivity register, locked while interrupts are enabled
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sensitivity_control_reg <= eic_pkg::SENS_RESET;
        end else if (sens_write) begin
            sensitivity_control_reg <= reg_wdata;
        end
    end

    // pin selection register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            source_pin_select_reg <= eic_pkg::PSEL_RESET;
        end else if (reg_write && reg_addr == eic_pkg::PSEL_ADDR) begin
            source_pin_select_reg <= reg_wdata;
        end
    end

    // interrupt mask register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= eic_pkg::MASK_RESET;
        end else if (reg_write && reg_addr == eic_pkg::MASK_ADDR) begin
            mask_reg <= reg_wdata[3:0];
        end
    end

    // --------------------------------------------------------------
    // pin routing
    // --------------------------------------------------------------
    assign line3_pin_choice = source_pin_select_reg[7:6];
    assign line2_pin_choice = source_pin_select_reg[5:4];
    assign line1_pin_choice = source_pin_select_reg[3:2];
    assign line0_pin_choice = source_pin_select_reg[1:0];

    // raw pins go straight to the line synchronisers, never registered here
    always_comb begin
        src_valid = 4'hF;
        src_pin = 4'hF;
        unique case (line3_pin_choice)
            2'h0: src_pin[3] = port_b_pins[0];
            2'h1: src_pin[3] = port_b_pins[1];
            2'h2: src_pin[3] = port_b_pins[2];
            default: src_valid[3] = 1'b0;
        endcase
        src_pin[2] = port_b_pins[3 + line2_pin_choice];
        src_pin[1] = port_a_pins[4 + line1_pin_choice];
        src_pin[0] = port_a_pins[line0_pin_choice];
    end

    // --------------------------------------------------------------
    // per-line detection
    // --------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < eic_pkg::LINES; i++) begin : g_line
            // any write of a differing code that lands (core_int_mask set) counts as a change
            assign code_changed[i] = sens_write &&
                reg_wdata[2*i +: 2] != sensitivity_control_reg[2*i +: 2];
            eic_line u_line (
                .clock(clock),
                .reset_n(reset_n),
                .pin_raw(src_pin[i]),
                .source_valid(src_valid[i]),
                .trigger_code(sensitivity_control_reg[2*i +: 2]),
                .code_changed(code_changed[i]),
                .ack(service_ack[i]),
                .pending(pending[i]),
                .event_pulse(event_pulse[i])
            );
        end
    endgenerate

    // line 2 routed from port B line 4 cannot wake the core
    always_comb begin
        wake_ok = pending;
        if (line2_pin_choice == eic_pkg::LINE2_NOWAKE_CHOICE) begin
            wake_ok[2] = 1'b0;
        end
    end

    // --------------------------------------------------------------
    // core side outputs
    // --------------------------------------------------------------
    // requests held back while the global mask is set
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            req_reg <= 4'h0;
        end else begin
            req_reg <= core_int_mask ? 4'h0 : (pending & ~service_ack);
        end
    end

    // wake request, only meaningful during halt
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= halt_mode && (|wake_ok);
        end
    end

    // --------------------------------------------------------------
    // event status, read to clear; set wins over clear
    // --------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= 4'h0;
        end else if (reg_read && reg_addr == eic_pkg::STAT_ADDR) begin
            status_reg <= event_pulse;
        end else begin
            status_reg <= status_reg | event_pulse;
        end
    end

    // level interrupt from the status plus this cycle's event pulses, so it sets on the same edge as status
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(((status_reg | event_pulse) & ~({4{reg_read && reg_addr == eic_pkg::STAT_ADDR}}
                & status_reg)) & mask_reg);
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                eic_pkg::SENS_ADDR: rdata_reg <= sensitivity_control_reg;
                eic_pkg::PSEL_ADDR: rdata_reg <= source_pin_select_reg;
                eic_pkg::STAT_ADDR: rdata_reg <= {4'h0, status_reg};
                eic_pkg::MASK_ADDR: rdata_reg <= {4'h0, mask_reg};
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;
    assign int_request = req_reg;
    assign halt_wake = wake_reg;
    assign irq = irq_reg;
endmodule : eic_top

// ### eic_top_asserts.sv
// assertion checker for the external interrupt configuration block
`timescale 1ns/1ns
module eic_top_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // core side
    input wire logic core_int_mask,
    input wire logic halt_mode,
    input wire logic [3:0] service_ack,
    input wire logic [3:0] int_request,
    input wire logic halt_wake,
    input wire logic irq
);
    logic [7:0] sens_q;
    logic [7:0] psel_q;
    logic [3:0] mask_q;
    wire sens_wr = reg_write && core_int_mask && reg_addr == 2'h0;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ----
    // mirrors of the writable registers, so readback needs no view of the body
    // ----
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sens_q <= 8'h00;
            psel_q <= 8'h0C;
            mask_q <= 4'h0;
        end else begin
            if (sens_wr) sens_q <= reg_wdata;
            if (reg_write && reg_addr == 2'h1) psel_q <= reg_wdata;
            if (reg_write && reg_addr == 2'h3) mask_q <= reg_wdata[3:0];
        end
    end
    chk_mask_holds: assert property (core_int_mask |=> int_request == 4'h0)
        else $error("request while core masked");
    chk_ack_drops: assert property (|service_ack |=> (int_request & $past(service_ack)) == 4'h0)
        else $error("request kept through ack");
    chk_code_clears: assert property (sens_wr && reg_wdata[1:0] != sens_q[1:0] |=> ##1 !int_request[0])
        else $error("line 0 kept after code change");
    chk_sens_read: assert property (reg_read && reg_addr == 2'h0 |=> reg_rdata == $past(sens_q))
        else $error("sensitivity readback wrong");
    chk_psel_read: assert property (reg_read && reg_addr == 2'h1 |=> reg_rdata == $past(psel_q))
        else $error("pin select readback wrong");
    chk_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    chk_irq_masked: assert property (mask_q == 4'h0 |=> !irq)
        else $error("irq with all sources masked");
    chk_wake_halt: assert property (!halt_mode |=> !halt_wake)
        else $error("wake outside halt");
endmodule : eic_top_asserts
bind eic_top eic_top_asserts i_chk (.*);

// ### eic_pin_model.sv
// port pin model: pins idle high and follow the bench's wished levels
`timescale 1ns/1ns
module eic_pin_model (
    // clock
    input wire logic clock,
    // wished levels {port b, port a} and pacing
    input wire logic [14:0] level_want,
    input wire logic slow,
    // port pins
    output logic [7:0] port_a_pins,
    output logic [6:0] port_b_pins
);
    logic [14:0] stage_q = 15'h7FFF;
    logic [14:0] pins_q = 15'h7FFF;
    // slow mode adds a cycle, so edges land at a different phase
    always @(posedge clock) begin
        stage_q <= level_want;
        pins_q <= slow ? stage_q : level_want;
    end
    assign {port_b_pins, port_a_pins} = pins_q;
endmodule : eic_pin_model

// ### eic_top_tb_top.sv
// self-checking bench for the external interrupt configuration block
`timescale 1ns/1ns
module eic_top_tb_top;
    logic clock = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic core_int_mask = 1'b1, halt_mode = 1'b0, rd_seen = 1'b0, slow = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [3:0] service_ack = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, port_a_pins, rnd, sw, sv = 8'h00, rq[$], oq[$];
    logic [6:0] port_b_pins;
    logic [3:0] int_request, cum;
    logic halt_wake, irq;
    logic [14:0] want = 15'h7FFF, m[4];
    int errors = 0, checked = 0, seed = 32'h9C0377E9, n;
    always #5 clock = ~clock;
    eic_top i_dut (.*);
    eic_pin_model i_pins (.clock(clock), .level_want(want), .slow(slow), .port_a_pins(port_a_pins),
        .port_b_pins(port_b_pins));
    // ----
    // bus and pin tasks; addresses 0 sens, 1 pin select, 2 status, 3 mask
    // ----
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        rq.push_back(e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
    endtask : rd
    // outputs {halt_wake, irq, int_request} noted after a settling span
    task automatic outs(input int cyc, input logic [7:0] e);
        repeat (cyc) @(posedge clock);
        oq.push_back(e);
        @(posedge clock);
    endtask : outs
    task automatic pins(input logic [14:0] v);
        @(posedge clock);
        want <= v;
    endtask : pins
    task automatic ack;
        @(posedge clock);
        service_ack <= 4'hF;
        @(posedge clock);
        service_ack <= 4'h0;
    endtask : ack
    // line n runs trigger code c+n; lut is indexed by code
    function automatic logic [3:0] hit(input int c, input logic [3:0] lut);
        for (int i = 0; i < 4; i++) hit[i] = lut[(c + i) % 4];
    endfunction : hit
    task automatic summarize;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    // watcher takes the oldest note once its result is due
    always @(posedge clock) rd_seen <= reg_read;
    always @(negedge clock) begin
        if (rd_seen) cmp("rdata", rq.pop_front(), reg_rdata);
        if (oq.size() > 0) cmp("outputs", oq.pop_front(), {2'h0, halt_wake, irq, int_request});
    end
    // watchdog, about twenty times the expected run
    initial begin
        #100000;
        errors++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h0C);
        rd(2'h2, 8'h00);
        $display("reset test done");
        // random contents; sensitivity writes land only while the core is masked
        repeat (6) begin
            rnd = $random(seed);
            wr(2'h1, rnd);
            rd(2'h1, rnd);
            core_int_mask <= rnd[0];
            wr(2'h0, rnd ^ 8'h5A);
            sv = rnd[0] ? rnd ^ 8'h5A : sv;
            rd(2'h0, sv);
        end
        wr(2'h1, 8'h0C);
        wr(2'h3, 8'h0F);
        $display("register test done");
        // every trigger code on every line, default pins
        for (int c = 0; c < 4; c++) begin
            for (int i = 0; i < 4; i++) sw[2 * i +: 2] = 2'(c + i);
            core_int_mask <= 1'b1;
            wr(2'h0, sw);
            rd(2'h2, c == 0 ? 8'h00 : 8'h0F);
            core_int_mask <= 1'b0;
            pins(15'h767E);
            cum = hit(c, 4'b1101);
            outs(8, {3'h0, |cum, cum});
            ack();
            outs(4, {4'h1, hit(c, 4'b0001)});
            pins(15'h7FFF);
            outs(8, {4'h1, hit(c, 4'b1011)});
            ack();
            outs(4, 8'h10);
        end
        rd(2'h2, 8'h0F);
        $display("trigger test done");
        // pending kept under core mask, cleared only for a changed code
        core_int_mask <= 1'b1;
        wr(2'h0, 8'hAA);
        pins(15'h767E);
        outs(8, 8'h10);
        wr(2'h0, 8'hAB);
        core_int_mask <= 1'b0;
        outs(4, 8'h1E);
        wr(2'h0, 8'h00);
        outs(4, 8'h1E);
        pins(15'h7FFF);
        outs(8, 8'h1F);
        ack();
        rd(2'h2, 8'h0F);
        wr(2'h3, 8'h00);
        core_int_mask <= 1'b1;
        wr(2'h0, 8'hAA);
        core_int_mask <= 1'b0;
        halt_mode <= 1'b1;
        $display("clear test done");
        // each pin choice; others fall first, then lines 2,3,0,1 one by one
        for (int k = 0; k < 4; k++) begin
            slow <= k[0];
            for (int i = 0; i < 4; i++) m[i] = 15'h0001 << (i == 0 ? k : i == 1 ? 4 + k : i == 2 ? 11 + k : 8 + k);
            wr(2'h1, {4{2'(k)}});
            pins(m[0] | m[1] | m[2] | m[3]);
            outs(8, 8'h00);
            cum = 4'h0;
            for (int j = 0; j < 4; j++) begin
                n = (j + 2) % 4;
                pins(want & ~m[n]);
                cum[n] = !(n == 3 && k == 3);
                outs(8, {2'h0, |(cum & (k == 1 ? 4'hB : 4'hF)), 1'b0, cum});
            end
            pins(15'h7FFF);
            ack();
            outs(4, 8'h00);
        end
        halt_mode <= 1'b0;
        $display("routing test done");
        summarize();
    end
endmodule : eic_top_tb_top
